// [rbes_top.sv]
// Purpose: Return data buffer and error message stack of a motion controller host port
// Assumes: One clock hclk at 100 MHz, AHB-Lite slave, asynchronous active-low reset
// Notes:   Command queue is modelled only as far as the write handshake and packet check
`timescale 1ns/1ps
`include "rbes_map.svh"
// Overview of operation
// - return data queued first in, sixteen deep
// - data-available flag while return buffer non-empty
// - full buffer drops data, records error
// - modal error pushes command, resource, code
// - error stack returns newest entry first
// - error-pending clears when stack empties
// - stack holds ten, discards when full
// - code zero none; accept timeout code
// - bad packet code on incomplete packets
// - packet: identifier, command words, terminator
// - command queue sixteen; full holds host off
module rbes_top
   import rbes_pkg::*;
#(
   parameter int RET_DEPTH = `RBES_RET_DEPTH,
   parameter int ERR_DEPTH = `RBES_ERR_DEPTH,
   parameter int CMD_DEPTH = `RBES_CMD_DEPTH
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             irq,
   input  rbes_word_s       ret_in,
   input  wire logic        modal_err,
   input  rbes_err_s        modal_ent,
   input  wire logic        cmd_pop,
   output rbes_word_s       cmd_out
);
   localparam int RW = $clog2(RET_DEPTH);
   localparam int RC = $clog2(RET_DEPTH + 1);
   localparam int QW = $clog2(CMD_DEPTH);
   localparam int QC = $clog2(CMD_DEPTH + 1);

   typedef enum logic [1:0] {PK_IDLE, PK_BODY} rbes_pkt_e;

   // ==================================================
   // Bus address phase capture
   logic            ph_valid_r;
   logic            ph_write_r;
   logic [7:0]      ph_addr_r;
   logic            rd_ret;
   logic            rd_err;
   logic            wr_hit;
   logic            wr_int_stat;
   logic            wr_int_mask;
   logic            wr_ctrl;
   logic            wr_cmd;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_valid_r <= 1'b0;
         ph_write_r <= 1'b0;
         ph_addr_r  <= 8'h00;
      end else if (ce && hready) begin
         ph_valid_r <= hsel && htrans[1];
         ph_write_r <= hwrite;
         ph_addr_r  <= haddr;
      end
   end

   // Pops happen on the address phase so the data phase shows the popped entry
   logic addr_rd;
   assign addr_rd = ce && hready && hsel && htrans[1] && !hwrite;
   assign rd_ret  = addr_rd && (haddr == `RBES_OFS_RET_DATA);
   assign rd_err  = addr_rd && (haddr == `RBES_OFS_ERR_DATA);
   assign wr_hit      = ce && ph_valid_r && ph_write_r;
   assign wr_int_stat = wr_hit && (ph_addr_r == `RBES_OFS_INT_STAT);
   assign wr_int_mask = wr_hit && (ph_addr_r == `RBES_OFS_INT_MASK);
   assign wr_ctrl     = wr_hit && (ph_addr_r == `RBES_OFS_CTRL);
   assign wr_cmd      = wr_hit && (ph_addr_r == `RBES_OFS_CMD_DATA);

   // ==================================================
   // Control
   logic flush;
   assign flush = wr_ctrl && hwdata[`RBES_CTRL_FLUSH];

   // ==================================================
   // Command queue and packet check
   logic [31:0]     cmd_mem [CMD_DEPTH];
   logic [QW-1:0]   cq_wp_r;
   logic [QW-1:0]   cq_rp_r;
   logic [QC-1:0]   cq_cnt_r;
   logic            cq_full;
   logic            cq_push;
   logic            cq_pop;
   rbes_pkt_e       pk_state_r;
   logic            pkt_err;
   logic            cmd_dropped;

   assign cq_full = (cq_cnt_r == QC'(CMD_DEPTH));
   assign cq_push = wr_cmd && !cq_full;
   assign cq_pop  = ce && cmd_pop && (cq_cnt_r != '0);
   // Word written while the host was held off is a protocol fault
   assign cmd_dropped = wr_cmd && cq_full;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cq_wp_r  <= '0;
         cq_rp_r  <= '0;
         cq_cnt_r <= '0;
      end else if (ce) begin
         if (cq_push) begin
            cq_wp_r <= (cq_wp_r == QW'(CMD_DEPTH - 1)) ? '0 : cq_wp_r + QW'(1);
         end
         if (cq_pop) begin
            cq_rp_r <= (cq_rp_r == QW'(CMD_DEPTH - 1)) ? '0 : cq_rp_r + QW'(1);
         end
         cq_cnt_r <= cq_cnt_r + QC'(cq_push) - QC'(cq_pop);
      end
   end

   always_ff @(posedge hclk) begin
      if (cq_push) begin
         cmd_mem[cq_wp_r] <= hwdata;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_out <= '0;
      end else if (ce) begin
         cmd_out.valid <= cq_pop;
         cmd_out.data  <= cq_pop ? cmd_mem[cq_rp_r] : 32'h0000_0000;
      end
   end

   // Packet framing: bit 31 marks identifier, bit 30 marks terminator
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pk_state_r <= PK_IDLE;
      end else if (ce && cq_push) begin
         unique case (pk_state_r)
            PK_IDLE: begin
               if (hwdata[31]) begin
                  pk_state_r <= PK_BODY;
               end
            end
            PK_BODY: begin
               if (hwdata[30] || hwdata[31]) begin
                  pk_state_r <= hwdata[31] ? PK_BODY : PK_IDLE;
               end
            end
         endcase
      end
   end

   assign pkt_err = cq_push && (((pk_state_r == PK_IDLE) && !hwdata[31])
                    || ((pk_state_r == PK_BODY) && hwdata[31]));

   logic pkt_err_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pkt_err_r <= 1'b0;
      end else if (ce) begin
         if (pkt_err) begin
            pkt_err_r <= 1'b1;
         end else if (flush) begin
            pkt_err_r <= 1'b0;
         end
      end
   end

   // ==================================================
   // Return FIFO
   logic [31:0]     ret_mem [RET_DEPTH];
   logic [RW-1:0]   rf_wp_r;
   logic [RW-1:0]   rf_rp_r;
   logic [RC-1:0]   rf_cnt_r;
   logic            rf_full;
   logic            rf_push;
   logic            rf_pop;
   logic            rf_ovf;

   assign rf_full = (rf_cnt_r == RC'(RET_DEPTH));
   assign rf_pop  = rd_ret && (rf_cnt_r != '0);
   assign rf_push = ce && ret_in.valid && (!rf_full || rf_pop);
   assign rf_ovf  = ce && ret_in.valid && rf_full && !rf_pop;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rf_wp_r  <= '0;
         rf_rp_r  <= '0;
         rf_cnt_r <= '0;
      end else if (ce) begin
         if (flush) begin
            rf_wp_r  <= '0;
            rf_rp_r  <= '0;
            rf_cnt_r <= '0;
         end else begin
            if (rf_push) begin
               rf_wp_r <= (rf_wp_r == RW'(RET_DEPTH - 1)) ? '0 : rf_wp_r + RW'(1);
            end
            if (rf_pop) begin
               rf_rp_r <= (rf_rp_r == RW'(RET_DEPTH - 1)) ? '0 : rf_rp_r + RW'(1);
            end
            rf_cnt_r <= rf_cnt_r + RC'(rf_push) - RC'(rf_pop);
         end
      end
   end

   always_ff @(posedge hclk) begin
      if (rf_push && !flush) begin
         ret_mem[rf_wp_r] <= ret_in.data;
      end
   end

   // ==================================================
   // Error stack
   rbes_err_s   es_push_ent;
   rbes_err_s   es_top;
   logic        es_push;
   logic        es_pending;
   logic        es_full;

   // Overflow and packet faults take precedence over a same-cycle modal error
   always_comb begin
      es_push_ent = modal_ent;
      if (rf_ovf) begin
         es_push_ent = '{cmd_id: 8'h00, res_id: 8'h00, code: `RBES_CODE_RET_OVERFLOW};
      end else if (pkt_err || cmd_dropped) begin
         es_push_ent = '{cmd_id: 8'h00, res_id: 8'h00,
                         code: cmd_dropped ? `RBES_CODE_ACCEPT_TIMEOUT
                                           : `RBES_CODE_BAD_PACKET};
      end
   end
   assign es_push = ce && (modal_err || rf_ovf || pkt_err || cmd_dropped);

   rbes_err_stack #(
      .DEPTH (ERR_DEPTH)
   ) u_err_stack (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .ce        (ce),
      .clr       (flush),
      .push      (es_push),
      .push_ent  (es_push_ent),
      .pop       (rd_err),
      .top_ent   (es_top),
      .not_empty (es_pending),
      .full      (es_full)
   );

   // ==================================================
   // Status word and interrupts
   logic [31:0]               status_word;
   logic [`RBES_IS_WIDTH-1:0] int_stat_r;
   logic [`RBES_IS_WIDTH-1:0] int_mask_r;
   logic [`RBES_IS_WIDTH-1:0] int_evt;

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`RBES_ST_DATA_AVAIL] = (rf_cnt_r != '0);
      status_word[`RBES_ST_ERR_PEND]   = es_pending;
      status_word[`RBES_ST_MAY_WRITE]  = !cq_full;
      status_word[`RBES_ST_PKT_ERR]    = pkt_err_r;
   end

   assign int_evt = {pkt_err, es_push, rf_push};

   // Set wins over the write-one clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_stat_r <= '0;
         int_mask_r <= `RBES_MASK_RST;
      end else if (ce) begin
         int_stat_r <= (int_stat_r & ~(wr_int_stat ? hwdata[`RBES_IS_WIDTH-1:0] : '0))
                       | int_evt;
         if (wr_int_mask) begin
            int_mask_r <= hwdata[`RBES_IS_WIDTH-1:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else if (ce) begin
         irq <= |(int_stat_r & int_mask_r);
      end
   end

   // ==================================================
   // Read data, registered in the address phase
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (haddr)
         `RBES_OFS_STATUS:   rd_mux = status_word;
         `RBES_OFS_RET_DATA: rd_mux = (rf_cnt_r != '0) ? ret_mem[rf_rp_r] : 32'h0000_0000;
         `RBES_OFS_ERR_DATA: rd_mux = es_top.code;
         `RBES_OFS_INT_STAT: rd_mux = {29'h0, int_stat_r};
         `RBES_OFS_INT_MASK: rd_mux = {29'h0, int_mask_r};
         default:            rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else if (ce) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (addr_rd) begin
            hrdata <= (haddr == `RBES_OFS_ERR_DATA)
                      ? {es_top.cmd_id, es_top.res_id, es_top.code[15:0]} : rd_mux;
         end
      end
   end

   // ==================================================
   // Checks
   a_avail_tracks : assert property (@(posedge hclk) disable iff (!hresetn)
      ce && ret_in.valid && !flush && !rd_ret |=> status_word[`RBES_ST_DATA_AVAIL])
      else $error("Data-available not set after return data");
   a_ret_count : assert property (@(posedge hclk) disable iff (!hresetn)
      rf_cnt_r <= RC'(RET_DEPTH))
      else $error("Return buffer count above depth");
   a_ovf_pushes : assert property (@(posedge hclk) disable iff (!hresetn)
      rf_ovf && !flush |=> es_pending && $stable(rf_cnt_r))
      else $error("Overflow did not raise error pending");
   a_err_pend : assert property (@(posedge hclk) disable iff (!hresetn)
      ce && modal_err && !flush |=> status_word[`RBES_ST_ERR_PEND])
      else $error("Modal error did not raise error pending");
   sequence s_last_pop;
      ce && rd_err && !es_push && (u_err_stack.cnt_r == 1);
   endsequence
   a_pend_clear : assert property (@(posedge hclk) disable iff (!hresetn)
      s_last_pop |=> !status_word[`RBES_ST_ERR_PEND])
      else $error("Error pending stuck after last pop");
   a_lifo_order : assert property (@(posedge hclk) disable iff (!hresetn)
      ce && es_push && !es_full && !rd_err && !flush |=> es_top == $past(es_push_ent))
      else $error("Newest error not on top");
   a_hold_off : assert property (@(posedge hclk) disable iff (!hresetn)
      ce && cq_full && !cq_pop |=> !status_word[`RBES_ST_MAY_WRITE] && $stable(cq_wp_r))
      else $error("Full command queue released host or took a word");
   a_bad_code : assert property (@(posedge hclk) disable iff (!hresetn)
      pkt_err && !rf_ovf && !cmd_dropped |-> es_push_ent.code == `RBES_CODE_BAD_PACKET)
      else $error("Packet error pushed wrong code");
   a_timeout_code : assert property (@(posedge hclk) disable iff (!hresetn)
      cmd_dropped && !rf_ovf |-> es_push_ent.code == `RBES_CODE_ACCEPT_TIMEOUT)
      else $error("Dropped word pushed wrong code");
   a_reset_empty : assert property (@(posedge hclk)
      $rose(hresetn) |-> rf_cnt_r == '0 && !es_pending)
      else $error("Reset left buffers non-empty");
endmodule // rbes_top

// [rbes_map.svh]
// Purpose: Offsets, fields, reset values and counts of the return buffer / error stack
// Assumes: 32-bit AHB-Lite register bus, word aligned
// Notes:   Definitions only
`ifndef RBES_MAP_SVH
`define RBES_MAP_SVH
// =====================================================
// Register offsets
`define RBES_OFS_STATUS     8'h00
`define RBES_OFS_RET_DATA   8'h04
`define RBES_OFS_ERR_DATA   8'h08
`define RBES_OFS_INT_STAT   8'h0c
`define RBES_OFS_INT_MASK   8'h10
`define RBES_OFS_CTRL       8'h14
`define RBES_OFS_CMD_DATA   8'h18
// =====================================================
// Status word bits
`define RBES_ST_DATA_AVAIL  0
`define RBES_ST_ERR_PEND    1
`define RBES_ST_MAY_WRITE   2
`define RBES_ST_PKT_ERR     3
// Interrupt status bits
`define RBES_IS_RET_DATA    0
`define RBES_IS_ERROR       1
`define RBES_IS_PKT_ERR     2
`define RBES_IS_WIDTH       3
// Control bits
`define RBES_CTRL_FLUSH     0
// =====================================================
// Depths and codes
`define RBES_RET_DEPTH      16
`define RBES_ERR_DEPTH      10
`define RBES_CMD_DEPTH      16
`define RBES_CODE_NO_ERROR      32'sd0
`define RBES_CODE_ACCEPT_TIMEOUT -32'sd70001
`define RBES_CODE_BAD_PACKET    -32'sd70002
`define RBES_CODE_RET_OVERFLOW  -32'sd70003
`define RBES_MASK_RST       3'h0
`endif

// [rbes_pkg.sv]
// Purpose: Types of the return buffer / error stack
// Assumes: Nothing
// Notes:   Constants live in rbes_map.svh
package rbes_pkg;
   typedef struct packed {
      logic [7:0]  cmd_id;
      logic [7:0]  res_id;
      logic [31:0] code;
   } rbes_err_s;
   typedef struct packed {
      logic        valid;
      logic [31:0] data;
   } rbes_word_s;
endpackage

// [rbes_err_stack.sv]
// Purpose: Last-in-first-out error message stack
// Assumes: Push and pop are single-cycle pulses on hclk
// Notes:   Full stack drops new pushes
`timescale 1ns/1ps
module rbes_err_stack
   import rbes_pkg::*;
#(
   parameter int DEPTH = 10
) (
   input  wire logic      hclk,
   input  wire logic      hresetn,
   input  wire logic      ce,
   input  wire logic      clr,
   input  wire logic      push,
   input  rbes_err_s      push_ent,
   input  wire logic      pop,
   output rbes_err_s      top_ent,
   output logic           not_empty,
   output logic           full
);
   localparam int CW = $clog2(DEPTH + 1);
   rbes_err_s         mem [DEPTH];
   logic [CW-1:0]     cnt_r;
   logic              do_push;
   logic              do_pop;

   assign full      = (cnt_r == CW'(DEPTH));
   assign not_empty = (cnt_r != '0);
   assign do_pop    = pop && not_empty;
   assign do_push   = push && !full;
   assign top_ent   = not_empty ? mem[cnt_r - CW'(1)] : '0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= '0;
      end else if (ce) begin
         if (clr) begin
            cnt_r <= '0;
         end else if (do_push && do_pop) begin
            cnt_r <= cnt_r;
         end else if (do_push) begin
            cnt_r <= cnt_r + CW'(1);
         end else if (do_pop) begin
            cnt_r <= cnt_r - CW'(1);
         end
      end
   end

   // Simultaneous push and pop replaces the top entry
   always_ff @(posedge hclk) begin
      if (ce && !clr) begin
         if (do_push && do_pop) begin
            mem[cnt_r - CW'(1)] <= push_ent;
         end else if (do_push) begin
            mem[cnt_r] <= push_ent;
         end
      end
   end

   a_stack_full_hold : assert property (@(posedge hclk) disable iff (!hresetn)
      ce && full && !pop && !clr |=> full && $stable(top_ent))
      else $error("Full error stack changed without a pop");
endmodule // rbes_err_stack

// [rbes_host.sv]
// Purpose: Host driver model that reaches the block over AHB-Lite
// Assumes: One slave, hready fed back from its hreadyout, whole-word transfers
// Notes:   Tasks start just after a rising edge and end just after one
`timescale 1ns/1ps
`include "rbes_map.svh"
module rbes_host
   import rbes_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic      [7:0]  haddr,
   output logic      [1:0]  htrans,
   output logic             hwrite,
   output logic      [31:0] hwdata
);
   initial begin
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
   end
   // =====================================================
   // Single transfer
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd);
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   // =====================================================
   // Driver-level operations
   task automatic ret_word(output logic [31:0] d);
      xfer(`RBES_OFS_RET_DATA, 1'b0, 32'h0, d);
   endtask
   task automatic fetch_err(output logic pend, output logic [31:0] ent);
      logic [31:0] st;
      xfer(`RBES_OFS_STATUS, 1'b0, 32'h0, st);
      pend = st[`RBES_ST_ERR_PEND];
      ent = 32'h0;
      if (pend) xfer(`RBES_OFS_ERR_DATA, 1'b0, 32'h0, ent);
   endtask
   // Blind writes skip the handshake; used only to provoke a drop
   task automatic cmd_word(input logic [31:0] w, input logic blind, output logic sent);
      logic [31:0] st;
      logic [31:0] dummy;
      xfer(`RBES_OFS_STATUS, 1'b0, 32'h0, st);
      sent = blind | st[`RBES_ST_MAY_WRITE];
      if (sent) xfer(`RBES_OFS_CMD_DATA, 1'b1, w, dummy);
   endtask
endmodule // rbes_host

// [testbench.sv]
// Purpose: Self-checking bench of the return buffer and error stack
// Assumes: 100 MHz hclk, host model drives the bus
// Notes:   Each scenario judges its own results
`timescale 1ns/1ps
`include "rbes_map.svh"
module testbench
   import rbes_pkg::*;
;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        ce = 1'b1;
   logic        hsel = 1'b1;
   logic [2:0]  hsize = 3'h2;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        irq;
   rbes_word_s  ret_in = '0;
   logic        modal_err = 1'b0;
   rbes_err_s   modal_ent = '0;
   logic        cmd_pop = 1'b0;
   rbes_word_s  cmd_out;
   int          err_count = 0;
   int          total_checks = 0;
   int          cycles = 0;
   rbes_top uut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
      .ret_in(ret_in), .modal_err(modal_err), .modal_ent(modal_ent),
      .cmd_pop(cmd_pop), .cmd_out(cmd_out));
   rbes_host host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata));
   always #5 hclk = ~hclk;
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count = err_count + 1;
         close_out();
      end
   end
   // =====================================================
   // Helpers
   task automatic close_out();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask
   task automatic chk1(input string nm, input logic e, input logic g);
      total_checks++;
      if (g !== e) begin
         $display("wrong value %s expected %b seen %b", nm, e, g);
         err_count++;
      end
   endtask
   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      host.xfer(a, 1'b0, 32'h0, d);
      chk32(nm, e, d);
      chk1("hresp okay", 1'b0, hresp);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] d;
      host.xfer(a, 1'b1, v, d);
   endtask
   task automatic irq_chk(input logic e);
      repeat (2) @(posedge hclk);
      #1;
      chk1("irq", e, irq);
      @(posedge hclk);
   endtask
   task automatic err_code_chk(input logic [15:0] e);
      logic        p;
      logic [31:0] d;
      host.fetch_err(p, d);
      chk1("err pending", 1'b1, p);
      chk32("err code", {16'h0, e}, {16'h0, d[15:0]});
   endtask
   // =====================================================
   // Scenarios
   task automatic t_reset_vals();
      rd_chk("status", `RBES_OFS_STATUS, 32'h4);
      rd_chk("mask", `RBES_OFS_INT_MASK, 32'h0);
      rd_chk("unmapped", 8'h40, 32'h0);
      rd_chk("empty err", `RBES_OFS_ERR_DATA, 32'h0);
   endtask
   task automatic t_ret_fifo();
      logic [31:0] d;
      logic        p;
      for (int i = 0; i < 17; i++) begin
         ret_in <= '{valid: 1'b1, data: 32'h1000 + i};
         @(posedge hclk);
      end
      ret_in <= '0;
      repeat (3) @(posedge hclk);
      rd_chk("status", `RBES_OFS_STATUS, 32'h7);
      for (int i = 0; i < 16; i++) begin
         host.ret_word(d);
         chk32("ret word", 32'h1000 + i, d);
      end
      rd_chk("status", `RBES_OFS_STATUS, 32'h6);
      err_code_chk(16'hee8d);
      host.fetch_err(p, d);
      chk1("err pending", 1'b0, p);
   endtask
   task automatic t_err_stack();
      logic [31:0] d;
      logic        p;
      for (int i = 0; i < 11; i++) begin
         modal_ent <= '{cmd_id: 8'(i + 1), res_id: 8'h5a, code: 32'(i + 256)};
         modal_err <= 1'b1;
         @(posedge hclk);
      end
      modal_err <= 1'b0;
      repeat (2) @(posedge hclk);
      rd_chk("status", `RBES_OFS_STATUS, 32'h6);
      for (int i = 9; i >= 0; i--) begin
         host.fetch_err(p, d);
         chk32("err entry", {8'(i + 1), 8'h5a, 16'(i + 256)}, d);
      end
      host.fetch_err(p, d);
      chk1("err pending", 1'b0, p);
   endtask
   task automatic t_cmd_path();
      logic        s;
      logic [31:0] w;
      for (int i = 0; i < 16; i++) begin
         w = (i == 0) ? 32'h8000_0000 : (i == 15) ? 32'h4000_0000 : 32'(i);
         host.cmd_word(w, 1'b0, s);
         chk1("word sent", 1'b1, s);
      end
      rd_chk("status", `RBES_OFS_STATUS, 32'h0);
      host.cmd_word(32'h8000_0077, 1'b0, s);
      chk1("held off", 1'b0, s);
      host.cmd_word(32'h8000_0077, 1'b1, s);
      err_code_chk(16'hee8f);
      for (int i = 0; i < 16; i++) begin
         @(posedge hclk);
         cmd_pop <= 1'b1;
         @(posedge hclk);
         cmd_pop <= 1'b0;
         #1;
         chk1("cmd valid", 1'b1, cmd_out.valid);
         w = (i == 0) ? 32'h8000_0000 : (i == 15) ? 32'h4000_0000 : 32'(i);
         chk32("cmd word", w, cmd_out.data);
      end
      @(posedge hclk);
      rd_chk("status", `RBES_OFS_STATUS, 32'h4);
      host.cmd_word(32'h0000_0005, 1'b0, s);
      rd_chk("status", `RBES_OFS_STATUS, 32'he);
      err_code_chk(16'hee8e);
      wr(`RBES_OFS_CTRL, 32'h1);
      rd_chk("status", `RBES_OFS_STATUS, 32'h4);
      // Identifier arriving inside an open packet
      host.cmd_word(32'h8000_0001, 1'b0, s);
      host.cmd_word(32'h8000_0002, 1'b0, s);
      chk1("word sent", 1'b1, s);
      err_code_chk(16'hee8e);
   endtask
   task automatic t_irq();
      wr(`RBES_OFS_INT_STAT, 32'h7);
      rd_chk("int stat", `RBES_OFS_INT_STAT, 32'h0);
      ret_in <= '{valid: 1'b1, data: 32'h55};
      @(posedge hclk);
      ret_in <= '0;
      irq_chk(1'b0);
      rd_chk("int stat", `RBES_OFS_INT_STAT, 32'h1);
      wr(`RBES_OFS_INT_MASK, 32'h1);
      irq_chk(1'b1);
      wr(`RBES_OFS_INT_STAT, 32'h1);
      irq_chk(1'b0);
      modal_err <= 1'b1;
      @(posedge hclk);
      modal_err <= 1'b0;
      irq_chk(1'b0);
      wr(`RBES_OFS_INT_MASK, 32'h7);
      irq_chk(1'b1);
      wr(`RBES_OFS_INT_STAT, 32'h2);
      irq_chk(1'b0);
   endtask
   task automatic t_reset_mid();
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd_chk("status", `RBES_OFS_STATUS, 32'h4);
      rd_chk("ret empty", `RBES_OFS_RET_DATA, 32'h0);
      rd_chk("mask", `RBES_OFS_INT_MASK, 32'h0);
      chk1("irq", 1'b0, irq);
   endtask
   // =====================================================
   // Main sequence
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset_vals();
      t_ret_fifo();
      t_err_stack();
      t_cmd_path();
      t_irq();
      t_reset_mid();
      close_out();
   end
endmodule // testbench
